// *** mac_dma_pkg.sv ***
// Package of register offsets, field positions and reset values for the MAC DMA status block.
package mac_dma_pkg;

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [7:0] OFS_TRANSMIT_STATUS          = 8'h00;
  localparam logic [7:0] OFS_RECEIVE_QUEUE_POINTER    = 8'h04;
  localparam logic [7:0] OFS_TRANSMIT_QUEUE_POINTER   = 8'h08;
  localparam logic [7:0] OFS_RECEIVE_STATUS           = 8'h0C;
  localparam logic [7:0] OFS_INTERRUPT_STATUS         = 8'h10;
  localparam logic [7:0] OFS_INTERRUPT_ENABLE         = 8'h14;

  // ==========================================================================
  // Transmit status fields
  // ==========================================================================
  localparam int TS_OWNED     = 0;
  localparam int TS_COLLISION = 1;
  localparam int TS_RETRY     = 2;
  localparam int TS_ACTIVE    = 3;
  localparam int TS_EXHAUSTED = 4;
  localparam int TS_COMPLETE  = 5;
  localparam int TS_UNDERRUN  = 6;
  localparam int TS_WIDTH     = 7;

  // ==========================================================================
  // Receive status fields
  // ==========================================================================
  localparam int RS_NO_BUFFER = 0;
  localparam int RS_RECEIVED  = 1;
  localparam int RS_OVERRUN   = 2;
  localparam int RS_WIDTH     = 3;

  // ==========================================================================
  // Interrupt status fields
  // ==========================================================================
  localparam int IS_MGMT_DONE  = 0;
  localparam int IS_RX_DONE    = 1;
  localparam int IS_RX_OWNED   = 2;
  localparam int IS_TX_OWNED   = 3;
  localparam int IS_TX_UNDER   = 4;
  localparam int IS_RETRY      = 5;
  localparam int IS_TX_EXHAUST = 6;
  localparam int IS_TX_DONE    = 7;
  localparam int IS_WIDTH      = 8;

  // ==========================================================================
  // Queue pointers and reset values
  // ==========================================================================
  localparam int          QP_LOW_BITS   = 2;
  localparam int          QP_WRAP_COUNT = 1024;
  localparam logic [31:0] RESET_WORD    = 32'h0000_0000;

endpackage

// *** mac_flag_bank.sv ***
// Bank of sticky event flags with write-one-clear or clear-on-read release.
`timescale 1ns/1ns
`default_nettype none
module mac_flag_bank #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  // Events and clears
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic [WIDTH-1:0] clear_i,
  // Flags
  output logic      [WIDTH-1:0] flags_o
);

  initial
  begin
    if (WIDTH < 1 || WIDTH > 32)
    begin
      $error("mac_flag_bank width out of range");
    end
  end

  // An event arriving with its clear keeps the flag set.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : gen_flag
      always_ff @(posedge clock_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          flags_o[g] <= 1'b0;
        end
        else
        begin
          flags_o[g] <= set_i[g] | (flags_o[g] & ~clear_i[g]);
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// *** mac_queue_pointer.sv ***
// Descriptor queue pointer that loads a base, advances per buffer and wraps.
`timescale 1ns/1ns
`default_nettype none
module mac_queue_pointer #(
  parameter int WRAP_COUNT = mac_dma_pkg::QP_WRAP_COUNT
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Control
  input  wire logic        load_i,
  input  wire logic [31:0] base_i,
  input  wire logic        advance_i,
  input  wire logic        wrap_i,
  input  wire logic        restart_i,
  // Pointer
  output logic      [31:0] pointer_o
);

  localparam int CW = $clog2(WRAP_COUNT);

  initial
  begin
    if (WRAP_COUNT < 2)
    begin
      $error("mac_queue_pointer wrap count too small");
    end
  end

  logic [31:0] base_reg;
  logic [CW-1:0] count_reg;

  // Each descriptor is two words, so the pointer steps by eight bytes.
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      base_reg  <= mac_dma_pkg::RESET_WORD;
      pointer_o <= mac_dma_pkg::RESET_WORD;
      count_reg <= '0;
    end
    else if (load_i)
    begin
      base_reg  <= {base_i[31:mac_dma_pkg::QP_LOW_BITS], 2'h0};
      pointer_o <= {base_i[31:mac_dma_pkg::QP_LOW_BITS], 2'h0};
      count_reg <= '0;
    end
    else if (restart_i || (advance_i && (wrap_i || count_reg == CW'(WRAP_COUNT - 1))))
    begin
      pointer_o <= base_reg;
      count_reg <= '0;
    end
    else if (advance_i)
    begin
      pointer_o <= pointer_o + 32'h0000_0008;
      count_reg <= count_reg + CW'(1);
    end
  end

endmodule
`default_nettype wire

// *** mac_dma_status.sv ***
// Top of the MAC DMA status flags and descriptor queue pointers with an AHB-Lite slave.
//
// Functional notes
// - Transmit status flags cleared by writing one
// - Owned transmit descriptor sets flag and interrupt
// - Collision input sets sticky collision flag
// - Retry exhaustion sets sticky retry flag
// - Bit three shows live transmit activity
// - Exhausted buffers: stop, bad check, error
// - Completed frame sets sticky complete flag
// - Late fetch sets underrun, forces bad check
// - Receive pointer loads, advances and wraps
// - Receive pointer reads current descriptor address
// - Transmit pointer loads, advances and wraps
// - Transmit pointer writable only when idle
// - Transmit pointer reads current descriptor address
// - Receive status flags cleared by writing one
// - Owned receive descriptor sets no-buffer flag
// - Stored frame sets frame-received flag
// - Receive store failure sets overrun flag
// - Management done flag, cleared on read
// - Receive done flag, cleared on read
// - Owned receive descriptor flag, cleared on read
// - Underrun or pointer write, cleared on read
// - Exhausted buffers flag, cleared on read
// - Enable bits gate flags onto interrupt output
`timescale 1ns/1ns
`default_nettype none
module mac_dma_status (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [7:0]  haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Transmit engine events
  input  wire logic        tx_owned_descriptor_i,
  input  wire logic        collision_i,
  input  wire logic        retry_exhausted_i,
  input  wire logic        transmit_active_i,
  input  wire logic        tx_buffers_out_i,
  input  wire logic        tx_frame_done_i,
  input  wire logic        tx_fetch_late_i,
  input  wire logic        tx_buffer_used_i,
  input  wire logic        tx_descriptor_wrap_i,
  input  wire logic        tx_restart_i,
  // Receive engine events
  input  wire logic        rx_owned_descriptor_i,
  input  wire logic        rx_frame_stored_i,
  input  wire logic        rx_store_failed_i,
  input  wire logic        rx_buffer_used_i,
  input  wire logic        rx_descriptor_wrap_i,
  input  wire logic        management_done_i,
  // Transmit control outputs
  output logic             tx_stop_o,
  output logic             tx_bad_fcs_o,
  output logic             tx_error_o,
  // Pointers and interrupt
  output logic      [31:0] rx_pointer_o,
  output logic      [31:0] tx_pointer_o,
  output logic             irq_o
);

  // ==========================================================================
  // Reset release and input synchronisers
  // ==========================================================================
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  // The collision pin comes from the PHY and is synchronised before use.
  logic [1:0] col_sync_reg;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_sync_reg <= 2'h0;
      col_sync_reg <= 2'h0;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      col_sync_reg <= {col_sync_reg[0], collision_i};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ==========================================================================
  // Block state
  // ==========================================================================
  typedef struct packed {
    logic        data_phase;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] rdata;
    logic [mac_dma_pkg::IS_WIDTH-1:0] enable;
    logic        col_prev;
    logic        tx_stop;
    logic        tx_bad_fcs;
    logic        tx_error;
    logic        irq;
  } state_s;

  state_s state_reg;
  state_s state_next;

  logic [mac_dma_pkg::TS_WIDTH-1:0] ts_flags;
  logic [mac_dma_pkg::RS_WIDTH-1:0] rs_flags;
  logic [mac_dma_pkg::IS_WIDTH-1:0] is_flags;
  logic [mac_dma_pkg::TS_WIDTH-1:0] ts_set;
  logic [mac_dma_pkg::TS_WIDTH-1:0] ts_clear;
  logic [mac_dma_pkg::RS_WIDTH-1:0] rs_set;
  logic [mac_dma_pkg::RS_WIDTH-1:0] rs_clear;
  logic [mac_dma_pkg::IS_WIDTH-1:0] is_set;
  logic [mac_dma_pkg::IS_WIDTH-1:0] is_clear;
  logic        wr_data;
  logic        rd_taken;
  logic        tqp_load;
  logic        rqp_load;
  logic        col_rise;
  logic [31:0] rd_word;

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  assign wr_data  = state_reg.data_phase && state_reg.write;
  assign rd_taken = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  assign col_rise = col_sync_reg[1] && !state_reg.col_prev;

  assign tqp_load = wr_data && state_reg.addr == mac_dma_pkg::OFS_TRANSMIT_QUEUE_POINTER && !transmit_active_i;
  assign rqp_load = wr_data && state_reg.addr == mac_dma_pkg::OFS_RECEIVE_QUEUE_POINTER;

  // ==========================================================================
  // Flag sources
  // ==========================================================================
  always_comb
  begin
    ts_set = '0;
    ts_set[mac_dma_pkg::TS_OWNED]     = tx_owned_descriptor_i;
    ts_set[mac_dma_pkg::TS_COLLISION] = col_rise;
    ts_set[mac_dma_pkg::TS_RETRY]     = retry_exhausted_i;
    ts_set[mac_dma_pkg::TS_EXHAUSTED] = tx_buffers_out_i;
    ts_set[mac_dma_pkg::TS_COMPLETE]  = tx_frame_done_i;
    ts_set[mac_dma_pkg::TS_UNDERRUN]  = tx_fetch_late_i;
    ts_clear = '0;
    if (wr_data && state_reg.addr == mac_dma_pkg::OFS_TRANSMIT_STATUS)
    begin
      ts_clear = hwdata_i[mac_dma_pkg::TS_WIDTH-1:0];
    end
    ts_clear[mac_dma_pkg::TS_ACTIVE] = 1'b0;

    rs_set = '0;
    rs_set[mac_dma_pkg::RS_NO_BUFFER] = rx_owned_descriptor_i;
    rs_set[mac_dma_pkg::RS_RECEIVED]  = rx_frame_stored_i;
    rs_set[mac_dma_pkg::RS_OVERRUN]   = rx_store_failed_i;
    rs_clear = '0;
    if (wr_data && state_reg.addr == mac_dma_pkg::OFS_RECEIVE_STATUS)
    begin
      rs_clear = hwdata_i[mac_dma_pkg::RS_WIDTH-1:0];
    end

    is_set = '0;
    is_set[mac_dma_pkg::IS_MGMT_DONE]  = management_done_i;
    is_set[mac_dma_pkg::IS_RX_DONE]    = rx_frame_stored_i;
    is_set[mac_dma_pkg::IS_RX_OWNED]   = rx_owned_descriptor_i;
    is_set[mac_dma_pkg::IS_TX_OWNED]   = tx_owned_descriptor_i;
    is_set[mac_dma_pkg::IS_TX_UNDER]   = tx_fetch_late_i || tqp_load;
    is_set[mac_dma_pkg::IS_RETRY]      = retry_exhausted_i;
    is_set[mac_dma_pkg::IS_TX_EXHAUST] = tx_buffers_out_i;
    is_set[mac_dma_pkg::IS_TX_DONE]    = tx_frame_done_i;
    is_clear = '0;
    if (rd_taken && haddr_i == mac_dma_pkg::OFS_INTERRUPT_STATUS)
    begin
      is_clear = '1;
    end
  end

  mac_flag_bank #(
    .WIDTH (mac_dma_pkg::TS_WIDTH)
  ) u_tx_flags (
    .clock_i (clock_i),
    .rst_n_i (rst_n),
    .set_i   (ts_set),
    .clear_i (ts_clear),
    .flags_o (ts_flags)
  );

  mac_flag_bank #(
    .WIDTH (mac_dma_pkg::RS_WIDTH)
  ) u_rx_flags (
    .clock_i (clock_i),
    .rst_n_i (rst_n),
    .set_i   (rs_set),
    .clear_i (rs_clear),
    .flags_o (rs_flags)
  );

  mac_flag_bank #(
    .WIDTH (mac_dma_pkg::IS_WIDTH)
  ) u_irq_flags (
    .clock_i (clock_i),
    .rst_n_i (rst_n),
    .set_i   (is_set),
    .clear_i (is_clear),
    .flags_o (is_flags)
  );

  // ==========================================================================
  // Queue pointers
  // ==========================================================================
  // Transmit pointer advance
  mac_queue_pointer u_tx_queue (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n),
    .load_i    (tqp_load),
    .base_i    (hwdata_i),
    .advance_i (tx_buffer_used_i),
    .wrap_i    (tx_descriptor_wrap_i),
    .restart_i (tx_restart_i),
    .pointer_o (tx_pointer_o)
  );

  mac_queue_pointer u_rx_queue (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n),
    .load_i    (rqp_load),
    .base_i    (hwdata_i),
    .advance_i (rx_buffer_used_i),
    .wrap_i    (rx_descriptor_wrap_i),
    .restart_i (1'b0),
    .pointer_o (rx_pointer_o)
  );

  // ==========================================================================
  // Read mux and next state
  // ==========================================================================
  always_comb
  begin
    rd_word = mac_dma_pkg::RESET_WORD;
    case (haddr_i)
      mac_dma_pkg::OFS_TRANSMIT_STATUS:
      begin
        rd_word[mac_dma_pkg::TS_WIDTH-1:0] = ts_flags;
        rd_word[mac_dma_pkg::TS_ACTIVE] = transmit_active_i;
      end
      mac_dma_pkg::OFS_RECEIVE_QUEUE_POINTER:  rd_word = rx_pointer_o;
      mac_dma_pkg::OFS_TRANSMIT_QUEUE_POINTER: rd_word = tx_pointer_o;
      mac_dma_pkg::OFS_RECEIVE_STATUS:         rd_word[mac_dma_pkg::RS_WIDTH-1:0] = rs_flags;
      mac_dma_pkg::OFS_INTERRUPT_STATUS:       rd_word[mac_dma_pkg::IS_WIDTH-1:0] = is_flags;
      mac_dma_pkg::OFS_INTERRUPT_ENABLE:       rd_word[mac_dma_pkg::IS_WIDTH-1:0] = state_reg.enable;
      default:                                 rd_word = mac_dma_pkg::RESET_WORD;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    if (hready_i)
    begin
      state_next.data_phase = hsel_i && htrans_i[1];
      state_next.write      = hwrite_i;
      state_next.addr       = haddr_i;
    end
    if (rd_taken)
    begin
      state_next.rdata = rd_word;
    end
    if (wr_data && state_reg.addr == mac_dma_pkg::OFS_INTERRUPT_ENABLE)
    begin
      state_next.enable = hwdata_i[mac_dma_pkg::IS_WIDTH-1:0];
    end
    state_next.col_prev = col_sync_reg[1];
    // Stop with bad check and error line
    state_next.tx_stop    = tx_buffers_out_i;
    state_next.tx_error   = tx_buffers_out_i;
    state_next.tx_bad_fcs = tx_buffers_out_i || tx_fetch_late_i;
    state_next.irq        = |(is_flags & state_reg.enable);
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign hrdata_o     = state_reg.rdata;
  assign hreadyout_o  = 1'b1;
  assign hresp_o      = 1'b0;
  assign tx_stop_o    = state_reg.tx_stop;
  assign tx_bad_fcs_o = state_reg.tx_bad_fcs;
  assign tx_error_o   = state_reg.tx_error;
  assign irq_o        = state_reg.irq;

  // ==========================================================================
  // Checks
  // ==========================================================================
  chk_tx_complete_sticky: assert property (@(posedge clock_i) disable iff (!rst_n)
    tx_frame_done_i |=> ts_flags[mac_dma_pkg::TS_COMPLETE]) else $error("complete flag not set");
  chk_tx_write_no_set: assert property (@(posedge clock_i) disable iff (!rst_n)
    !ts_flags[mac_dma_pkg::TS_UNDERRUN] && !tx_fetch_late_i |=> !ts_flags[mac_dma_pkg::TS_UNDERRUN])
    else $error("underrun flag set without event");
  chk_rx_write_no_set: assert property (@(posedge clock_i) disable iff (!rst_n)
    !rs_flags[mac_dma_pkg::RS_OVERRUN] && !rx_store_failed_i |=> !rs_flags[mac_dma_pkg::RS_OVERRUN])
    else $error("overrun flag set without event");
  chk_rx_owned_both: assert property (@(posedge clock_i) disable iff (!rst_n)
    rx_owned_descriptor_i |=> rs_flags[mac_dma_pkg::RS_NO_BUFFER] && is_flags[mac_dma_pkg::IS_RX_OWNED])
    else $error("owned receive descriptor not flagged");
  chk_isr_read_clears: assert property (@(posedge clock_i) disable iff (!rst_n)
    rd_taken && haddr_i == mac_dma_pkg::OFS_INTERRUPT_STATUS && !rx_frame_stored_i
    |=> !is_flags[mac_dma_pkg::IS_RX_DONE]) else $error("read did not clear receive done");
  chk_tqp_busy_hold: assert property (@(posedge clock_i) disable iff (!rst_n)
    wr_data && transmit_active_i && !tx_buffer_used_i && !tx_restart_i |=> $stable(tx_pointer_o))
    else $error("pointer loaded while active");
  chk_tqp_write_irq: assert property (@(posedge clock_i) disable iff (!rst_n)
    tqp_load |=> is_flags[mac_dma_pkg::IS_TX_UNDER]) else $error("pointer write not flagged");
  chk_exhaust_outputs: assert property (@(posedge clock_i) disable iff (!rst_n)
    tx_buffers_out_i |=> tx_stop_o && tx_error_o && tx_bad_fcs_o) else $error("exhaustion outputs missing");
  chk_pointer_align: assert property (@(posedge clock_i) disable iff (!rst_n)
    tx_pointer_o[1:0] == 2'h0 && rx_pointer_o[1:0] == 2'h0) else $error("pointer low bits not zero");
  chk_irq_gating: assert property (@(posedge clock_i) disable iff (!rst_n)
    (is_flags & state_reg.enable) == '0 |=> !irq_o) else $error("interrupt without enabled flag");

endmodule
`default_nettype wire

// *** mac_dma_partner.sv ***
// Model of the DMA engines that raise event pulses and levels toward the status block.
`timescale 1ns/1ns
`default_nettype none
module mac_dma_partner (
  // Clock
  input  wire logic        clock_i,
  // Event pulses and levels
  output logic      [13:0] events_o,
  output logic             collision_o,
  output logic             active_o
);
  // ==========================================================================
  // Stimulus
  // ==========================================================================
  initial
  begin
    events_o    = 14'h0000;
    collision_o = 1'b0;
    active_o    = 1'b0;
  end

  task automatic fire(input logic [13:0] mask);
    @(posedge clock_i);
    events_o <= mask;
    @(posedge clock_i);
    events_o <= 14'h0000;
  endtask

  task automatic hold(input logic col, input logic act);
    @(posedge clock_i);
    collision_o <= col;
    active_o    <= act;
  endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench of the MAC DMA status block.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ==========================================================================
  // Signals
  // ==========================================================================
  localparam logic [7:0] A_TX  = mac_dma_pkg::OFS_TRANSMIT_STATUS;
  localparam logic [7:0] A_RXQ = mac_dma_pkg::OFS_RECEIVE_QUEUE_POINTER;
  localparam logic [7:0] A_TXQ = mac_dma_pkg::OFS_TRANSMIT_QUEUE_POINTER;
  localparam logic [7:0] A_RS  = mac_dma_pkg::OFS_RECEIVE_STATUS;
  localparam logic [7:0] A_IS  = mac_dma_pkg::OFS_INTERRUPT_STATUS;
  localparam logic [7:0] A_IE  = mac_dma_pkg::OFS_INTERRUPT_ENABLE;
  logic        clock;
  logic        rst_n;
  logic [1:0]  htrans;
  logic [7:0]  haddr;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic [13:0] ev;
  logic        col;
  logic        act;
  logic        stop;
  logic        bad;
  logic        err;
  logic [31:0] rxp;
  logic [31:0] txp;
  logic        irq;
  logic        seen_exh = 1'b0;
  logic        seen_und = 1'b0;
  logic [31:0] rd;
  int          n_fail;
  int          check_count;

  mac_dma_status mac_dma_status_i (
    .clock_i(clock), .rst_n_i(rst_n),
    .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(),
    .tx_owned_descriptor_i(ev[0]), .collision_i(col), .retry_exhausted_i(ev[1]),
    .transmit_active_i(act), .tx_buffers_out_i(ev[2]), .tx_frame_done_i(ev[3]),
    .tx_fetch_late_i(ev[4]), .tx_buffer_used_i(ev[5]), .tx_descriptor_wrap_i(ev[6]),
    .tx_restart_i(ev[7]), .rx_owned_descriptor_i(ev[8]), .rx_frame_stored_i(ev[9]),
    .rx_store_failed_i(ev[10]), .rx_buffer_used_i(ev[11]), .rx_descriptor_wrap_i(ev[12]),
    .management_done_i(ev[13]), .tx_stop_o(stop), .tx_bad_fcs_o(bad), .tx_error_o(err),
    .rx_pointer_o(rxp), .tx_pointer_o(txp), .irq_o(irq)
  );

  mac_dma_partner mac_dma_partner_i (
    .clock_i(clock), .events_o(ev), .collision_o(col), .active_o(act)
  );

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic fire(input logic [13:0] m);
    mac_dma_partner_i.fire(m);
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_tx_flags();
    logic [31:0] ts [5] = '{32'h01, 32'h04, 32'h10, 32'h20, 32'h40};
    logic [31:0] is [5] = '{32'h08, 32'h20, 32'h40, 32'h80, 32'h10};
    for (int i = 0; i < 5; i++)
    begin
      fire(14'h0001 << i);
      rchk(A_TX, ts[i]);
      ahb(1'b1, A_TX, 32'h0000_0000);
      rchk(A_TX, ts[i]);
      ahb(1'b1, A_TX, 32'h0000_007F);
      rchk(A_TX, 32'h0);
      rchk(A_IS, is[i]);
      rchk(A_IS, 32'h0);
    end
    chk({31'h0, seen_exh}, 32'h1);
    chk({31'h0, seen_und}, 32'h1);
    mac_dma_partner_i.hold(1'b1, 1'b0);
    repeat (5) @(posedge clock);
    rchk(A_TX, 32'h02);
    ahb(1'b1, A_TX, 32'h0000_0002);
    rchk(A_TX, 32'h0);
    mac_dma_partner_i.hold(1'b0, 1'b0);
  endtask

  task automatic t_tx_ptr();
    mac_dma_partner_i.hold(1'b0, 1'b1);
    rchk(A_TX, 32'h08);
    ahb(1'b1, A_TXQ, 32'h0000_1000);
    rchk(A_TXQ, 32'h0);
    mac_dma_partner_i.hold(1'b0, 1'b0);
    rchk(A_TX, 32'h0);
    ahb(1'b0, A_IS, 32'h0000_0000);
    ahb(1'b1, A_TXQ, 32'h0000_2003);
    rchk(A_TXQ, 32'h2000);
    rchk(A_IS, 32'h10);
    fire(14'h0020);
    fire(14'h0020);
    rchk(A_TXQ, 32'h2010);
    fire(14'h0080);
    rchk(A_TXQ, 32'h2000);
    fire(14'h0020);
    fire(14'h0060);
    @(negedge clock);
    chk(txp, 32'h2000);
  endtask

  task automatic t_rx_ptr();
    ahb(1'b1, A_RXQ, 32'h0001_0003);
    rchk(A_RXQ, 32'h0001_0000);
    repeat (1023) fire(14'h0800);
    rchk(A_RXQ, 32'h0001_1FF8);
    fire(14'h0800);
    rchk(A_RXQ, 32'h0001_0000);
    fire(14'h0800);
    fire(14'h1800);
    @(negedge clock);
    chk(rxp, 32'h0001_0000);
  endtask

  task automatic t_rx_flags();
    logic [13:0] ev_t [4] = '{14'h0100, 14'h0200, 14'h0400, 14'h2000};
    logic [31:0] rs [4] = '{32'h1, 32'h2, 32'h4, 32'h0};
    logic [31:0] is [4] = '{32'h4, 32'h2, 32'h0, 32'h1};
    for (int i = 0; i < 4; i++)
    begin
      fire(ev_t[i]);
      rchk(A_RS, rs[i]);
      ahb(1'b1, A_RS, 32'h0000_0007);
      rchk(A_RS, 32'h0);
      rchk(A_IS, is[i]);
      rchk(A_IS, 32'h0);
    end
  endtask

  task automatic t_irq();
    ahb(1'b1, A_IE, 32'h0000_0002);
    fire(14'h0200);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    rchk(A_IS, 32'h2);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    fire(14'h2000);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
  endtask

  // ==========================================================================
  // Clock, reset, monitor and sequence
  // ==========================================================================
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    if (stop === 1'b1 && bad === 1'b1 && err === 1'b1)
      seen_exh <= 1'b1;
    if (stop === 1'b0 && bad === 1'b1 && err === 1'b0)
      seen_und <= 1'b1;
  end

  initial
  begin
    #200000;
    n_fail++;
    print_verdict();
  end

  initial
  begin
    {rst_n, htrans, haddr, hwrite, hwdata, n_fail, check_count} = '0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    for (int a = 0; a <= 24; a += 4)
      rchk(a[7:0], 32'h0);
    t_tx_flags();
    t_tx_ptr();
    t_rx_ptr();
    t_rx_flags();
    t_irq();
    print_verdict();
  end
endmodule
`default_nettype wire
